// >>> rtl/lcdhi_pkg.sv
// Purpose: shared constants of the lcd driver host interface
// Assumes: 40 MHz core clock
// Notes: command codes and status layout are local choices
package lcdhi_pkg;
   localparam int unsigned LCDHI_PAGES = 18;
   localparam int unsigned LCDHI_COLS = 180;
   localparam logic [4:0] LCDHI_PAGE_LAST = 5'h11;
   localparam logic [7:0] LCDHI_COL_LAST = 8'hB3;
   localparam logic [4:0] LCDHI_PAGE_RST = 5'h00;
   localparam logic [7:0] LCDHI_COL_RST = 8'h00;
   localparam logic [7:0] LCDHI_BYTE_RST = 8'h00;
   // command decoding: page set 101p_pppp, column high 0001_cccc,
   // column low 0000_cccc, input direction 1000_010d
   localparam logic [2:0] LCDHI_CMD_PAGE = 3'h5;
   localparam logic [3:0] LCDHI_CMD_COL_HI = 4'h1;
   localparam logic [3:0] LCDHI_CMD_COL_LO = 4'h0;
   localparam logic [6:0] LCDHI_CMD_DIR = 7'h42;
   // upper five bits of the i2c slave address; value is arbitrary
   localparam logic [4:0] LCDHI_I2C_ADDR_HI = 5'h0F;
   localparam int unsigned LCDHI_I2C_BITS = 8;
   localparam logic [2:0] LCDHI_SER_LAST = 3'h7;
   typedef enum logic [2:0] {
      LCDHI_I_IDLE,
      LCDHI_I_ADDR,
      LCDHI_I_CTRL,
      LCDHI_I_ONE,
      LCDHI_I_STREAM,
      LCDHI_I_SKIP
   } lcdhi_i2c_e;
endpackage : lcdhi_pkg

// >>> rtl/lcdhi_sync.sv
// Purpose: two flip-flop synchroniser for a group of levels
// Assumes: bits of the group are independent levels
// Notes: first stage is read by the second stage only
`timescale 1ns/10ps
`default_nettype none
module lcdhi_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else if (clk_en)
      begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule : lcdhi_sync
`default_nettype wire

// >>> rtl/lcdhi_serial.sv
// Purpose: clocked serial input shifter on the host's serial clock
// Assumes: host holds data_command_select stable around the 8th edge
// Notes: byte words cross to the core by a toggle with held data
`timescale 1ns/10ps
`default_nettype none
module lcdhi_serial (
   input wire logic serial_clock,
   input wire logic link_reset,
   input wire logic link_clear,
   input wire logic serial_data_in,
   input wire logic data_command_select,
   output logic [7:0] byte_q,
   output logic dc_q,
   output logic toggle_q
);
   import lcdhi_pkg::*;

   logic [6:0] shift_q;
   logic [2:0] count_q;

   // clear is the inactive chip select; reset listed too, as clear may
   // already stand high when reset comes and then gives no edge
   always_ff @(posedge serial_clock or posedge link_clear or posedge link_reset)
   begin
      if (link_clear || link_reset)
      begin
         shift_q <= 7'h00;
         count_q <= 3'h0;
      end
      else
      begin
         shift_q <= {shift_q[5:0], serial_data_in};
         count_q <= count_q + 3'h1;
      end
   end

   // kept apart from the chip-select clear so no false toggle appears
   always_ff @(posedge serial_clock or posedge link_reset)
   begin
      if (link_reset)
      begin
         byte_q <= 8'h00;
         dc_q <= 1'b0;
         toggle_q <= 1'b0;
      end
      else if (!link_clear && count_q == LCDHI_SER_LAST)
      begin
         byte_q <= {shift_q, serial_data_in};
         dc_q <= data_command_select;
         toggle_q <= ~toggle_q;
      end
   end
endmodule : lcdhi_serial
`default_nettype wire

// >>> rtl/lcdhi_top.sv
// Purpose: host access logic of a dot-matrix lcd driver
// Assumes: parallel pins asynchronous to clock; i2c oversampled
// Notes: display refresh reads through its own registered port
`timescale 1ns/10ps
`default_nettype none
module lcdhi_top
   import lcdhi_pkg::*;
#(
   parameter int unsigned PAGES = LCDHI_PAGES,
   parameter int unsigned COLS = LCDHI_COLS,
   parameter logic [4:0] I2C_ADDR_HI = LCDHI_I2C_ADDR_HI
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic host_port_select,
   input wire logic bus_flavour_select,
   input wire logic chip_select_low,
   input wire logic chip_select_high,
   input wire logic data_command_select,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe,
   input wire logic serial_clock,
   input wire logic serial_data_in,
   output logic ack_output_out,
   output logic ack_output_oe,
   input wire logic [4:0] disp_page,
   input wire logic [7:0] disp_col,
   output logic [7:0] disp_data
);
   import lcdhi_pkg::*;

   // read_strobe_n is the enable strobe and write_strobe_n the
   // read/write select when the 68-series flavour is chosen
   logic [14:0] pin_s;
   logic [1:0] i2c_s;
   logic psel, fsel, cs_l, cs_h, dc_s, rd_s, wr_s;
   logic [7:0] db_s;
   logic scl_s, sda_s;
   logic par_mode, ser_mode, i2c_mode, cs_on;
   logic rd_act, wr_act, rd_prev_q, wr_prev_q;
   logic rd_start, wr_end;
   logic [7:0] wdata_q;
   logic wdc_q;
   logic [7:0] ser_byte;
   logic ser_dc, ser_tog, tog_s, tog_seen_q, ser_evt;
   logic link_reset, link_clear;
   logic scl_q, sda_q, start_c, stop_c, rise_c, fall_c;
   lcdhi_i2c_e i2c_state_q;
   logic [7:0] i2c_sr_q;
   logic [3:0] i2c_cnt_q;
   logic i2c_rs_q, i2c_evt_q;
   logic [7:0] i2c_byte_q;
   logic [6:0] my_addr;
   logic wev;
   logic wdc;
   logic [7:0] wbyte;
   logic [4:0] page_q;
   logic [7:0] col_q;
   logic dir_q;
   logic [7:0] holder_q;
   logic commit_q, fetch_q;
   logic [7:0] ram [PAGES*COLS];

   function automatic int unsigned ram_index(input logic [4:0] pg,
                                             input logic [7:0] cl);
      ram_index = int'(pg) * COLS + int'(cl);
   endfunction : ram_index

   lcdhi_sync #(.W(15)) u_pin_sync (
      .clock(clock),
      .resetn(resetn),
      .clk_en(clk_en),
      .d({host_port_select, bus_flavour_select, chip_select_low,
          chip_select_high, data_command_select, read_strobe_n,
          write_strobe_n, host_data_in}),
      .q(pin_s)
   );

   lcdhi_sync #(.W(2)) u_i2c_sync (
      .clock(clock),
      .resetn(resetn),
      .clk_en(clk_en),
      .d({serial_clock, serial_data_in}),
      .q(i2c_s)
   );

   lcdhi_sync #(.W(1)) u_tog_sync (
      .clock(clock),
      .resetn(resetn),
      .clk_en(clk_en),
      .d(ser_tog),
      .q(tog_s)
   );

   assign {psel, fsel, cs_l, cs_h, dc_s, rd_s, wr_s, db_s} = pin_s;
   assign {scl_s, sda_s} = i2c_s;

   assign par_mode = psel;
   assign ser_mode = !psel && fsel;
   assign i2c_mode = !psel && !fsel;
   assign cs_on = !cs_l && cs_h;

   // raw pins drive the link clear; the link clock stops outside frames
   assign link_reset = !resetn;
   assign link_clear = !resetn || host_port_select || !bus_flavour_select
                       || chip_select_low || !chip_select_high;

   lcdhi_serial u_serial (
      .serial_clock(serial_clock),
      .link_reset(link_reset),
      .link_clear(link_clear),
      .serial_data_in(serial_data_in),
      .data_command_select(data_command_select),
      .byte_q(ser_byte),
      .dc_q(ser_dc),
      .toggle_q(ser_tog)
   );

   // parallel strobes as access levels
   assign rd_act = par_mode && cs_on && (fsel ? (rd_s && wr_s) : !rd_s);
   assign wr_act = par_mode && cs_on && (fsel ? (rd_s && !wr_s) : !wr_s);
   assign rd_start = rd_act && !rd_prev_q;
   assign wr_end = !wr_act && wr_prev_q;

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         rd_prev_q <= 1'b0;
         wr_prev_q <= 1'b0;
         wdata_q <= LCDHI_BYTE_RST;
         wdc_q <= 1'b0;
      end
      else if (clk_en)
      begin
         rd_prev_q <= rd_act;
         wr_prev_q <= wr_act;
         if (wr_act)
         begin
            wdata_q <= db_s;
            wdc_q <= dc_s;
         end
      end
   end

   // data lines driven only during a selected parallel read
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         host_data_out <= LCDHI_BYTE_RST;
         host_data_oe <= 1'b0;
      end
      else if (clk_en)
      begin
         host_data_oe <= rd_act;
         if (rd_start)
            host_data_out <= dc_s ? holder_q : {2'b00, dir_q, page_q};
      end
   end

   // serial byte arrival by toggle crossing
   assign ser_evt = (tog_s != tog_seen_q) && ser_mode;

   always_ff @(posedge clock)
   begin
      if (!resetn)
         tog_seen_q <= 1'b0;
      else if (clk_en)
         tog_seen_q <= tog_s;
   end

   // i2c, oversampled on the core clock
   assign my_addr = {I2C_ADDR_HI, cs_h, cs_l};
   assign start_c = i2c_mode && scl_s && scl_q && sda_q && !sda_s;
   assign stop_c = i2c_mode && scl_s && scl_q && !sda_q && sda_s;
   assign rise_c = scl_s && !scl_q;
   assign fall_c = !scl_s && scl_q;

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else if (clk_en)
      begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         i2c_state_q <= LCDHI_I_IDLE;
         i2c_sr_q <= LCDHI_BYTE_RST;
         i2c_cnt_q <= 4'h0;
         i2c_rs_q <= 1'b0;
         i2c_evt_q <= 1'b0;
         i2c_byte_q <= LCDHI_BYTE_RST;
         ack_output_oe <= 1'b0;
      end
      else if (clk_en)
      begin
         i2c_evt_q <= 1'b0;
         if (!i2c_mode || stop_c)
         begin
            i2c_state_q <= LCDHI_I_IDLE;
            ack_output_oe <= 1'b0;
         end
         else if (start_c)
         begin
            i2c_state_q <= LCDHI_I_ADDR;
            i2c_cnt_q <= 4'h0;
            ack_output_oe <= 1'b0;
         end
         else if (i2c_state_q != LCDHI_I_IDLE && i2c_state_q != LCDHI_I_SKIP)
         begin
            if (rise_c)
            begin
               if (i2c_cnt_q < 4'(LCDHI_I2C_BITS))
               begin
                  i2c_sr_q <= {i2c_sr_q[6:0], sda_s};
                  i2c_cnt_q <= i2c_cnt_q + 4'h1;
               end
               else
                  i2c_cnt_q <= 4'h0;
            end
            else if (fall_c && i2c_cnt_q == 4'(LCDHI_I2C_BITS))
            begin
               unique case (i2c_state_q)
                  LCDHI_I_ADDR:
                  begin
                     if (i2c_sr_q[7:1] == my_addr && !i2c_sr_q[0])
                     begin
                        ack_output_oe <= 1'b1;
                        i2c_state_q <= LCDHI_I_CTRL;
                     end
                     else
                        i2c_state_q <= LCDHI_I_SKIP;
                  end
                  LCDHI_I_CTRL:
                  begin
                     ack_output_oe <= 1'b1;
                     i2c_rs_q <= i2c_sr_q[6];
                     i2c_state_q <= i2c_sr_q[7] ? LCDHI_I_ONE : LCDHI_I_STREAM;
                  end
                  LCDHI_I_ONE:
                  begin
                     ack_output_oe <= 1'b1;
                     i2c_evt_q <= 1'b1;
                     i2c_byte_q <= i2c_sr_q;
                     i2c_state_q <= LCDHI_I_CTRL;
                  end
                  default:
                  begin
                     ack_output_oe <= 1'b1;
                     i2c_evt_q <= 1'b1;
                     i2c_byte_q <= i2c_sr_q;
                  end
               endcase
            end
            else if (fall_c && i2c_cnt_q == 4'h0)
               ack_output_oe <= 1'b0;
         end
      end
   end

   // open drain: only ever pulls low
   always_ff @(posedge clock)
   begin
      if (!resetn)
         ack_output_out <= 1'b0;
      else if (clk_en)
         ack_output_out <= 1'b0;
   end

   // one write stream from whichever port is active
   always_comb
   begin
      wev = 1'b0;
      wdc = 1'b0;
      wbyte = LCDHI_BYTE_RST;
      if (wr_end)
      begin
         wev = 1'b1;
         wdc = wdc_q;
         wbyte = wdata_q;
      end
      else if (ser_evt)
      begin
         wev = 1'b1;
         wdc = ser_dc;
         wbyte = ser_byte;
      end
      else if (i2c_evt_q)
      begin
         wev = 1'b1;
         wdc = i2c_rs_q;
         wbyte = i2c_byte_q;
      end
   end

   // address, holder and commands; one access per host cycle, no waits
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         page_q <= LCDHI_PAGE_RST;
         col_q <= LCDHI_COL_RST;
         dir_q <= 1'b0;
         holder_q <= LCDHI_BYTE_RST;
         commit_q <= 1'b0;
         fetch_q <= 1'b0;
      end
      else if (clk_en)
      begin
         commit_q <= 1'b0;
         fetch_q <= 1'b0;
         if (commit_q || fetch_q)
         begin
            if (fetch_q)
               holder_q <= ram[ram_index(page_q, col_q)];
            if (dir_q)
            begin
               if (page_q >= LCDHI_PAGE_LAST)
               begin
                  page_q <= LCDHI_PAGE_RST;
                  col_q <= (col_q >= LCDHI_COL_LAST) ? LCDHI_COL_RST : col_q + 8'h01;
               end
               else
                  page_q <= page_q + 5'h01;
            end
            else if (col_q >= LCDHI_COL_LAST)
            begin
               col_q <= LCDHI_COL_RST;
               page_q <= (page_q >= LCDHI_PAGE_LAST) ? LCDHI_PAGE_RST : page_q + 5'h01;
            end
            else
               col_q <= col_q + 8'h01;
         end
         else if (rd_start && dc_s)
            fetch_q <= 1'b1;
         else if (wev && wdc)
         begin
            holder_q <= wbyte;
            commit_q <= 1'b1;
         end
         else if (wev)
         begin
            if (wbyte[7:5] == LCDHI_CMD_PAGE && wbyte[4:0] <= LCDHI_PAGE_LAST)
               page_q <= wbyte[4:0];
            else if (wbyte[7:4] == LCDHI_CMD_COL_HI)
               col_q <= {wbyte[3:0], col_q[3:0]};
            else if (wbyte[7:4] == LCDHI_CMD_COL_LO)
               col_q <= {col_q[7:4], wbyte[3:0]};
            else if (wbyte[7:1] == LCDHI_CMD_DIR)
               dir_q <= wbyte[0];
         end
      end
   end

   // ram write; bit n of a byte is the n-th dot down the column
   always_ff @(posedge clock)
   begin
      if (clk_en && commit_q)
         ram[ram_index(page_q, col_q)] <= holder_q;
   end

   // refresh port has its own read path, untouched by host cycles
   always_ff @(posedge clock)
   begin
      if (!resetn)
         disp_data <= LCDHI_BYTE_RST;
      else if (clk_en)
         disp_data <= ram[ram_index(disp_page, disp_col)];
   end
endmodule : lcdhi_top
`default_nettype wire

// >>> verif/lcdhi_top_asserts.sv
// Purpose: port checks of the lcd host interface
// Assumes: one core clock, synchronous reset
// Notes: link side is judged by the bench
`timescale 1ns/10ps
`default_nettype none
module lcdhi_top_chk (
   input wire logic clock,
   input wire logic resetn,
   input wire logic host_port_select,
   input wire logic bus_flavour_select,
   input wire logic chip_select_low,
   input wire logic chip_select_high,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe,
   input wire logic ack_output_out,
   input wire logic ack_output_oe
);
   logic rd_act;
   logic [2:0] idle_q;
   // 68 read is enable high with read/write high
   assign rd_act = host_port_select && !chip_select_low && chip_select_high &&
      (bus_flavour_select ? read_strobe_n && write_strobe_n : !read_strobe_n);
   always_ff @(posedge clock)
   begin
      if (!resetn || rd_act)
         idle_q <= 3'h0;
      else if (idle_q != 3'h7)
         idle_q <= idle_q + 3'h1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   ack_low_a: assert property (ack_output_out == 1'h0)
      else $error("ack level high");
   ack_mode_a: assert property
      (ack_output_oe |-> !host_port_select && !bus_flavour_select) else $error("ack outside i2c");
   oe_release_a: assert property (idle_q == 3'h7 |-> !host_data_oe)
      else $error("bus driven when idle");
   oe_cause_a: assert property ($rose(host_data_oe) |-> $past(rd_act, 2))
      else $error("bus driven without read");
   oe_timely_a: assert property ($rose(rd_act) |-> ##[1:5] host_data_oe)
      else $error("read answer late");
   oe_stands_a: assert property (host_data_oe && rd_act |=> host_data_oe)
      else $error("bus dropped in read");
   data_stable_a: assert property
      (rd_act && host_data_oe && $past(host_data_oe) |-> $stable(host_data_out))
      else $error("read data moved");
   reset_quiet_a: assert property
      (disable iff (1'h0) !resetn |=> !host_data_oe && !ack_output_oe)
      else $error("output active after reset");
endmodule : lcdhi_top_chk
bind lcdhi_top lcdhi_top_chk u_chk (.clock, .resetn, .host_port_select, .bus_flavour_select,
   .chip_select_low, .chip_select_high, .read_strobe_n, .write_strobe_n, .host_data_out,
   .host_data_oe, .ack_output_out, .ack_output_oe);
`default_nettype wire

// >>> verif/lcdhi_host.sv
// Purpose: host model driving the lcd interface pins
// Assumes: core clock paces the parallel and i2c cycles
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/10ps
`default_nettype none
module lcdhi_host (
   input wire logic clock,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe,
   input wire logic ack_output_oe,
   output logic host_port_select,
   output logic bus_flavour_select,
   output logic chip_select_low,
   output logic chip_select_high,
   output logic data_command_select,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output wire logic [7:0] host_data_in,
   output logic serial_clock,
   output wire logic serial_data_in
);
   logic [7:0] hd_q = 8'h00;
   logic sda;
   // pulled-up wire, acknowledge pulls it low
   assign serial_data_in = sda & ~ack_output_oe;
   assign host_data_in = host_data_oe ? host_data_out : hd_q;
   initial
   begin
      {host_port_select, bus_flavour_select, chip_select_low, chip_select_high,
         data_command_select, read_strobe_n, write_strobe_n, serial_clock, sda} = 9'h14D;
   end
   task automatic mode(input logic p, input logic f, input logic l, input logic h);
      @(negedge clock);
      {host_port_select, bus_flavour_select, chip_select_low, chip_select_high} = {p, f, l, h};
      read_strobe_n = !(p && f);
      repeat (8) @(negedge clock);
   endtask : mode
   // 6 clock strobes and gaps, well past the pin synchronisers
   task automatic acc(input logic dc, input logic rd, input logic [7:0] d, output logic [8:0] r);
      @(negedge clock);
      data_command_select = dc;
      if (!rd)
         hd_q = d;
      if (bus_flavour_select)
      begin
         write_strobe_n = rd;
         read_strobe_n = 1'h1;
      end
      else if (rd)
         read_strobe_n = 1'h0;
      else
         write_strobe_n = 1'h0;
      repeat (6) @(negedge clock);
      r = {host_data_oe, host_data_in};
      read_strobe_n = !bus_flavour_select;
      // 68 keeps direction until the enable has fallen
      write_strobe_n = bus_flavour_select ? rd : 1'h1;
      repeat (6) @(negedge clock);
      write_strobe_n = 1'h1;
      hd_q = ~hd_q;
   endtask : acc
   // link clock runs only inside a byte
   task automatic ser(input logic dc, input logic [7:0] b, input int n);
      data_command_select = dc;
      for (int i = 7; i > 7 - n; i--)
      begin
         sda = b[i];
         #16 serial_clock = 1'h1;
         #16 serial_clock = 1'h0;
      end
      #16 sda = ~sda;
   endtask : ser
   task automatic bitx(input logic v, output logic o);
      repeat (4) @(negedge clock);
      sda = v;
      repeat (4) @(negedge clock);
      serial_clock = 1'h1;
      repeat (4) @(negedge clock);
      o = ack_output_oe;
      repeat (4) @(negedge clock);
      serial_clock = 1'h0;
   endtask : bitx
   task automatic i2c_byte(input logic [7:0] b, output logic a);
      for (int i = 7; i >= 0; i--)
         bitx(b[i], a);
      bitx(1'h1, a);
   endtask : i2c_byte
   task automatic i2c_start;
      sda = 1'h1;
      serial_clock = 1'h1;
      repeat (8) @(negedge clock);
      sda = 1'h0;
      repeat (8) @(negedge clock);
      serial_clock = 1'h0;
   endtask : i2c_start
   task automatic i2c_stop;
      repeat (4) @(negedge clock);
      sda = 1'h0;
      repeat (4) @(negedge clock);
      serial_clock = 1'h1;
      repeat (8) @(negedge clock);
      sda = 1'h1;
      repeat (8) @(negedge clock);
   endtask : i2c_stop
endmodule : lcdhi_host
`default_nettype wire

// >>> verif/lcdhi_top_test.sv
// Purpose: self-checking bench of the lcd host interface
// Assumes: ram contents seen through the refresh port
// Notes: i2c address pins strapped to 2'b01
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) \
   begin compares++; if ((a) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module lcdhi_top_test;
   import lcdhi_pkg::*;
   logic clock = 1'h0;
   logic resetn = 1'h1;
   logic [4:0] disp_page = 5'h00;
   logic [7:0] disp_col = 8'h00;
   logic ser_m = 1'h0;
   logic a;
   logic [8:0] r;
   int errors = 0;
   int compares = 0;
   logic [7:0] bad [2] = '{{LCDHI_I2C_ADDR_HI, 3'h4}, {LCDHI_I2C_ADDR_HI, 3'h3}};
   logic [7:0] good [10] = '{{LCDHI_I2C_ADDR_HI, 3'h2}, 8'hBF, {LCDHI_CMD_PAGE, 5'h07}, 8'h80,
      {LCDHI_CMD_COL_HI, 4'h0}, 8'h80, {LCDHI_CMD_COL_LO, 4'h0}, 8'h7F, 8'h83, 8'h18};
   wire hps, bfs, csl, csh, dcs, rdn, wrn, sck, sdi, oe, ack_oe;
   wire [7:0] hdi, hdo, disp_data;
   always #12.5 clock = ~clock;
   lcdhi_top i_dut (.clock, .resetn, .clk_en(1'h1), .host_port_select(hps),
      .bus_flavour_select(bfs), .chip_select_low(csl), .chip_select_high(csh),
      .data_command_select(dcs), .read_strobe_n(rdn), .write_strobe_n(wrn),
      .host_data_in(hdi), .host_data_out(hdo), .host_data_oe(oe), .serial_clock(sck),
      .serial_data_in(sdi), .ack_output_out(), .ack_output_oe(ack_oe), .disp_page,
      .disp_col, .disp_data);
   lcdhi_host i_host (.clock, .host_data_out(hdo), .host_data_oe(oe), .ack_output_oe(ack_oe),
      .host_port_select(hps), .bus_flavour_select(bfs), .chip_select_low(csl),
      .chip_select_high(csh), .data_command_select(dcs), .read_strobe_n(rdn),
      .write_strobe_n(wrn), .host_data_in(hdi), .serial_clock(sck), .serial_data_in(sdi));
   task automatic put(input logic dc, input logic [7:0] b);
      if (ser_m)
         i_host.ser(dc, b, 8);
      else
         i_host.acc(dc, 1'h0, b, r);
   endtask : put
   task automatic adr(input logic [4:0] p, input logic [7:0] c);
      put(1'h0, {LCDHI_CMD_PAGE, p});
      put(1'h0, {LCDHI_CMD_COL_HI, c[7:4]});
      put(1'h0, {LCDHI_CMD_COL_LO, c[3:0]});
   endtask : adr
   task automatic dum;
      i_host.acc(1'h1, 1'h1, 8'h00, r);
   endtask : dum
   task automatic rdc(input logic dc, input logic [7:0] e);
      i_host.acc(dc, 1'h1, 8'h00, r);
      `CHK(r, {1'h1, e})
   endtask : rdc
   task automatic dchk(input logic [4:0] p, input logic [7:0] c, input logic [7:0] e);
      @(negedge clock);
      disp_page = p;
      disp_col = c;
      repeat (6) @(negedge clock);
      `CHK(disp_data, e)
   endtask : dchk
   task automatic i2(input logic [7:0] b, input logic e);
      i_host.i2c_byte(b, a);
      `CHK(a, e)
   endtask : i2
   task automatic test_done;
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   // whole sequence needs under 100 us
   initial
   begin
      #400_000;
      errors++;
      test_done();
   end
   initial
   begin
      // a real falling edge, so the link domain's reset fires
      #1 resetn = 1'h0;
      repeat (12) @(negedge clock);
      resetn = 1'h1;
      i_host.mode(1'h1, 1'h0, 1'h0, 1'h1);
      adr(5'h02, 8'hB2);
      put(1'h1, 8'h5A);
      put(1'h1, 8'hC3);
      put(1'h1, 8'h3C);
      dchk(5'h02, 8'hB2, 8'h5A);
      dchk(5'h02, 8'hB3, 8'hC3);
      dchk(5'h03, 8'h00, 8'h3C);
      rdc(1'h0, 8'h03);
      adr(5'h02, 8'hB2);
      dum();
      rdc(1'h1, 8'h5A);
      rdc(1'h1, 8'hC3);
      adr(5'h03, 8'h00);
      i_host.mode(1'h1, 1'h0, 1'h0, 1'h0);
      put(1'h1, 8'hFF);
      dum();
      `CHK(r[8], 1'h0)
      i_host.mode(1'h1, 1'h0, 1'h0, 1'h1);
      dchk(5'h03, 8'h00, 8'h3C);
      put(1'h0, {LCDHI_CMD_DIR, 1'h1});
      adr(5'h11, 8'h05);
      put(1'h1, 8'h11);
      put(1'h1, 8'h22);
      dchk(5'h11, 8'h05, 8'h11);
      dchk(5'h00, 8'h06, 8'h22);
      rdc(1'h0, 8'h21);
      put(1'h0, {LCDHI_CMD_DIR, 1'h0});
      i_host.mode(1'h1, 1'h1, 1'h0, 1'h1);
      adr(5'h04, 8'h00);
      put(1'h1, 8'h77);
      adr(5'h04, 8'h00);
      dum();
      rdc(1'h1, 8'h77);
      ser_m = 1'h1;
      i_host.mode(1'h0, 1'h1, 1'h0, 1'h1);
      adr(5'h06, 8'h00);
      put(1'h1, 8'h96);
      i_host.ser(1'h1, 8'hFF, 3);
      i_host.mode(1'h0, 1'h1, 1'h1, 1'h1);
      i_host.mode(1'h0, 1'h1, 1'h0, 1'h1);
      put(1'h1, 8'h4C);
      dchk(5'h06, 8'h00, 8'h96);
      dchk(5'h06, 8'h01, 8'h4C);
      ser_m = 1'h0;
      i_host.mode(1'h0, 1'h0, 1'h1, 1'h0);
      for (int k = 0; k < 2; k++)
      begin
         i_host.i2c_start();
         i2(bad[k], 1'h0);
         i2(8'h40, 1'h0);
         i_host.i2c_stop();
      end
      i_host.i2c_start();
      foreach (good[k])
         i2(good[k], 1'h1);
      i_host.i2c_stop();
      dchk(5'h07, 8'h00, 8'h83);
      dchk(5'h07, 8'h01, 8'h18);
      test_done();
   end
endmodule : lcdhi_top_test
`default_nettype wire
